//--- src/lbc_bus_ctrl.sv
// Multiplexed local bus cycle sequencer and control strobes
// Contract
// - Address latch strobe is high during the address phase of each cycle.
// - Upper byte enable goes low when the cycle uses the upper data byte.
// - Bit zero with byte enable encode word, even byte, odd byte, refresh.
// - The upper byte enable pin doubles as the refresh indicator.
// - Transceiver enable is low only while data is transferred, high otherwise.
// - Transceiver direction high means write, low means read.
// - Timing reference output runs at half the input clock rate.
// - Timing reference toggles on every falling input edge, even duty cycle.
// - Low address bits in address phase, then data on the shared lines.
// - Upper four address bits in address phase, driven zero in data phase.
`timescale 1ns/1ps
module lbc_bus_ctrl #(
    parameter int AD_W = lbc_pkg::LBC_AD_W,
    parameter int ADDR_W = lbc_pkg::LBC_ADDR_W
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_byte,
    input wire logic req_refresh,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [AD_W-1:0] req_wdata,
    output logic done,
    output logic [AD_W-1:0] rdata,
    output logic [AD_W-1:0] ad_out,
    output logic ad_oe_n,
    input wire logic [AD_W-1:0] ad_in,
    output logic [lbc_pkg::LBC_HI_W-1:0] addr_hi,
    output logic ale,
    output logic bhe_n,
    output logic den_n,
    output logic transceiver_direction,
    output logic clkout
);
    localparam int LANE = lbc_pkg::LBC_LANE_W;

    lbc_pkg::lbc_state_t state_reg;
    logic phase_en;
    logic take;
    logic write_reg;
    logic refresh_reg;
    logic [AD_W-1:0] ad_out_reg;
    logic ad_oe_n_reg;
    logic [lbc_pkg::LBC_HI_W-1:0] addr_hi_reg;
    logic ale_reg;
    logic bhe_n_reg;
    logic den_n_reg;
    logic dir_reg;
    logic done_reg;
    logic [AD_W-1:0] rdata_reg;
    logic [AD_W-1:0] wdata_reg;
    logic [AD_W-1:0] ad_meta_reg;
    logic [AD_W-1:0] ad_sync_reg;

    lbc_clkgen u_clkgen (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clkout(clkout),
        .phase_en(phase_en)
    );

    // Byte enable from access size and address bit zero; refresh forces it high
    function automatic logic lbc_bhe_n(input logic is_refresh, input logic is_byte, input logic a0);
        if (is_refresh) begin
            return 1'b1;
        end else if (is_byte) begin
            return ~a0;
        end else begin
            return 1'b0;
        end
    endfunction

    assign req_ready = (state_reg == lbc_pkg::LBC_IDLE) && phase_en;
    assign take = req_valid && req_ready;

    // One phase per internal clock
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= lbc_pkg::LBC_IDLE;
        end else if (take) begin
            state_reg <= lbc_pkg::LBC_T1;
        end else if (phase_en) begin
            case (state_reg)
                lbc_pkg::LBC_T1: state_reg <= lbc_pkg::LBC_T2;
                lbc_pkg::LBC_T2: state_reg <= lbc_pkg::LBC_T3;
                lbc_pkg::LBC_T3: state_reg <= lbc_pkg::LBC_T4;
                lbc_pkg::LBC_T4: state_reg <= lbc_pkg::LBC_IDLE;
                default: state_reg <= lbc_pkg::LBC_IDLE;
            endcase
        end
    end

    // Cycle attributes captured with the request
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            write_reg <= 1'b0;
            refresh_reg <= 1'b0;
            wdata_reg <= '0;
        end else if (take) begin
            write_reg <= req_write && !req_refresh;
            refresh_reg <= req_refresh;
            // Byte writes appear on both lanes so either half serves the target
            wdata_reg <= req_byte ? {req_wdata[LANE-1:0], req_wdata[LANE-1:0]} : req_wdata;
        end
    end

    // Shared lines: address in the first phase, then data or released for a read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ad_out_reg <= '0;
            ad_oe_n_reg <= 1'b1;
            addr_hi_reg <= '0;
        end else if (take) begin
            ad_out_reg <= req_addr[AD_W-1:0];
            ad_oe_n_reg <= 1'b0;
            addr_hi_reg <= req_addr[lbc_pkg::LBC_HI_LSB +: lbc_pkg::LBC_HI_W];
        end else if (phase_en && state_reg == lbc_pkg::LBC_T1) begin
            ad_out_reg <= write_reg ? wdata_reg : '0;
            ad_oe_n_reg <= !write_reg;
            addr_hi_reg <= '0;
        end else if (phase_en && state_reg == lbc_pkg::LBC_T3) begin
            ad_oe_n_reg <= 1'b1;
        end
    end

    // Latch strobe covers the address phase only
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ale_reg <= lbc_pkg::LBC_ALE_RST;
        end else if (take) begin
            ale_reg <= 1'b1;
        end else if (phase_en) begin
            ale_reg <= 1'b0;
        end
    end

    // Byte enable stands for the whole cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bhe_n_reg <= lbc_pkg::LBC_BHE_N_RST;
        end else if (take) begin
            bhe_n_reg <= lbc_bhe_n(req_refresh, req_byte, req_addr[0]);
        end else if (phase_en && state_reg == lbc_pkg::LBC_T4) begin
            bhe_n_reg <= lbc_pkg::LBC_BHE_N_RST;
        end
    end

    // Transceiver enable low in the data phases; refresh moves no data
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            den_n_reg <= lbc_pkg::LBC_DEN_N_RST;
        end else if (phase_en && state_reg == lbc_pkg::LBC_T1) begin
            den_n_reg <= refresh_reg;
        end else if (phase_en && state_reg == lbc_pkg::LBC_T3) begin
            den_n_reg <= 1'b1;
        end
    end

    // Direction set at request, when enable is still high, and held through the cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dir_reg <= lbc_pkg::LBC_DIR_RST;
        end else if (take && den_n_reg) begin
            dir_reg <= (req_write && !req_refresh) ? lbc_pkg::LBC_DIR_TX : lbc_pkg::LBC_DIR_RX;
        end
    end

    // Input lines come from pins, so two flops precede any use
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ad_meta_reg <= '0;
            ad_sync_reg <= '0;
        end else begin
            ad_meta_reg <= ad_in;
            ad_sync_reg <= ad_meta_reg;
        end
    end

    // Read data taken at the end of the cycle; the sync delay fits inside the last phase
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= phase_en && state_reg == lbc_pkg::LBC_T4;
            if (phase_en && state_reg == lbc_pkg::LBC_T4 && !write_reg && !refresh_reg) begin
                rdata_reg <= ad_sync_reg;
            end
        end
    end

    assign ad_out = ad_out_reg;
    assign ad_oe_n = ad_oe_n_reg;
    assign addr_hi = addr_hi_reg;
    assign ale = ale_reg;
    assign bhe_n = bhe_n_reg;
    assign den_n = den_n_reg;
    assign transceiver_direction = dir_reg;
    assign done = done_reg;
    assign rdata = rdata_reg;

    property p_ale_addr;
        @(posedge ref_clk) disable iff (!nrst)
        take |=> ale && !ad_oe_n && ad_out == $past(req_addr[AD_W-1:0]) ##1 ale ##1 !ale;
    endproperty
    a_ale_addr: assert property (p_ale_addr) else $error("latch strobe or address phase wrong");

    property p_bhe_upper;
        @(posedge ref_clk) disable iff (!nrst)
        take && !req_refresh && (!req_byte || req_addr[0]) |=> !bhe_n [*8];
    endproperty
    a_bhe_upper: assert property (p_bhe_upper) else $error("byte enable not low for upper lane");

    property p_encode;
        @(posedge ref_clk) disable iff (!nrst)
        take |=> bhe_n == ($past(req_refresh) ? 1'b1 : ($past(req_byte) ? ~ad_out[0] : 1'b0));
    endproperty
    a_encode: assert property (p_encode) else $error("cycle type encoding wrong");

    property p_refresh;
        @(posedge ref_clk) disable iff (!nrst)
        take && req_refresh |=> bhe_n && den_n && ad_out[0] == $past(req_addr[0]) ##1 (bhe_n && den_n) [*7];
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh indication wrong");

    property p_den_window;
        @(posedge ref_clk) disable iff (!nrst)
        !den_n |-> (state_reg == lbc_pkg::LBC_T2 || state_reg == lbc_pkg::LBC_T3) && !refresh_reg;
    endproperty
    a_den_window: assert property (p_den_window) else $error("transceiver enabled outside data transfer");

    property p_dir;
        @(posedge ref_clk) disable iff (!nrst)
        take && !req_refresh |=> transceiver_direction == $past(req_write);
    endproperty
    a_dir: assert property (p_dir) else $error("direction does not follow access type");

    property p_data_phase;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(den_n == 1'b0) |-> addr_hi == '0 && (ad_oe_n == !write_reg);
    endproperty
    a_data_phase: assert property (p_data_phase) else $error("data phase lines wrong");

    property p_dir_stable;
        @(posedge ref_clk) disable iff (!nrst)
        !den_n && !$past(den_n) |-> $stable(transceiver_direction);
    endproperty
    a_dir_stable: assert property (p_dir_stable) else $error("direction changed while enabled");

    c_write: cover property (@(posedge ref_clk) disable iff (!nrst) take && req_write ##[8:10] done);
    c_read: cover property (@(posedge ref_clk) disable iff (!nrst) take && !req_write && !req_refresh ##[8:10] done);
    c_refresh: cover property (@(posedge ref_clk) disable iff (!nrst) take && req_refresh ##[8:10] done);
endmodule

//--- src/lbc_pkg.sv
// Constants and types shared by the local bus control strobe logic
package lbc_pkg;
    // Bus cycle phases; each one lasts one internal clock (two input clocks)
    typedef enum logic [2:0] {
        LBC_IDLE,
        LBC_T1,
        LBC_T2,
        LBC_T3,
        LBC_T4
    } lbc_state_t;

    localparam int LBC_AD_W = 16;
    localparam int LBC_HI_W = 4;
    localparam int LBC_ADDR_W = 20;
    localparam int LBC_HI_LSB = 16;
    localparam int LBC_LANE_W = 8;
    localparam int LBC_IN_RATIO = 2;
    localparam int LBC_REF_PERIOD_NS = 8;

    // Reset values of the pins
    localparam logic LBC_ALE_RST = 1'b0;
    localparam logic LBC_BHE_N_RST = 1'b1;
    localparam logic LBC_DEN_N_RST = 1'b1;
    localparam logic LBC_DIR_RST = 1'b0;
    localparam logic LBC_CLKOUT_RST = 1'b0;

    // Direction encoding on the transceiver direction pin
    localparam logic LBC_DIR_TX = 1'b1;
    localparam logic LBC_DIR_RX = 1'b0;
endpackage

//--- src/lbc_clkgen.sv
// Half-rate timing reference and internal phase enable
`timescale 1ns/1ps
module lbc_clkgen (
    input wire logic ref_clk,
    input wire logic nrst,
    output logic clkout,
    output logic phase_en
);
    logic clkout_reg;
    logic phase_reg;

    // Reference toggles on every falling input edge: half rate, even duty
    always_ff @(negedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clkout_reg <= lbc_pkg::LBC_CLKOUT_RST;
        end else begin
            clkout_reg <= ~clkout_reg;
        end
    end

    // Rising-edge enable marks one internal clock in every two input clocks
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
        end
    end

    assign clkout = clkout_reg;
    assign phase_en = phase_reg;

    property p_half_rate;
        @(posedge ref_clk) disable iff (!nrst)
        phase_en |=> !phase_en;
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("phase enable not at half rate");

    // The release edge itself still holds reset, so toggling is only owed once reset was seen high
    property p_toggle;
        @(negedge ref_clk) disable iff (!nrst)
        $past(nrst) |-> clkout != $past(clkout);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("clock output missed a falling edge toggle");
endmodule

//--- tb/lbc_mem_model.sv
// Behavioural latch, transceiver and 16-bit memory on the far side of the local bus
`timescale 1ns/1ps
module lbc_mem_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ale,
    input wire logic bhe_n,
    input wire logic den_n,
    input wire logic transceiver_direction,
    input wire logic ad_oe_n,
    input wire logic [15:0] ad_out,
    input wire logic [3:0] addr_hi,
    output logic [15:0] ad_in
);
    logic [15:0] mem [0:15];
    logic [19:0] addr_reg;
    logic rd_reg;
    logic [15:0] ad_in_reg;

    // External latch captures the full address only while the strobe is high
    always_ff @(posedge ref_clk) begin
        if (ale) begin
            addr_reg <= {addr_hi, ad_out};
        end
    end

    // Lanes are picked by bit zero and the upper byte enable, as a real byte-wide memory would
    always_ff @(posedge ref_clk) begin
        if (!den_n && transceiver_direction && !ad_oe_n) begin
            if (!addr_reg[0]) begin
                mem[addr_reg[4:1]][7:0] <= ad_out[7:0];
            end
            if (!bhe_n) begin
                mem[addr_reg[4:1]][15:8] <= ad_out[15:8];
            end
        end
    end

    // Read data held until the next address phase; otherwise the lines wander so stale data never passes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_reg <= 1'b0;
            ad_in_reg <= 16'h5a5a;
        end else begin
            if (!den_n && !transceiver_direction) begin
                rd_reg <= 1'b1;
            end else if (ale) begin
                rd_reg <= 1'b0;
            end
            ad_in_reg <= rd_reg ? mem[addr_reg[4:1]] : ~ad_in_reg;
        end
    end

    assign ad_in = ad_in_reg;
endmodule

//--- tb/local_bus_control_signals_tb.sv
// Self-checking bench for the local bus control strobe sequencer
`timescale 1ns/1ps
module local_bus_control_signals_tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_byte = 1'b0;
    logic req_refresh = 1'b0;
    logic [19:0] req_addr = 20'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic req_ready, done, ad_oe_n, ale, bhe_n, den_n, transceiver_direction, clkout;
    logic [15:0] rdata, ad_out, ad_in;
    logic [3:0] addr_hi;
    int errors = 0;
    int check_count = 0;

    always #4 ref_clk = ~ref_clk;

    lbc_bus_ctrl u_dut (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_byte(req_byte), .req_refresh(req_refresh), .req_addr(req_addr),
        .req_wdata(req_wdata), .done(done), .rdata(rdata), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
        .ad_in(ad_in), .addr_hi(addr_hi), .ale(ale), .bhe_n(bhe_n), .den_n(den_n),
        .transceiver_direction(transceiver_direction), .clkout(clkout));

    lbc_mem_model u_mem (.ref_clk(ref_clk), .nrst(nrst), .ale(ale), .bhe_n(bhe_n), .den_n(den_n),
        .transceiver_direction(transceiver_direction), .ad_oe_n(ad_oe_n), .ad_out(ad_out),
        .addr_hi(addr_hi), .ad_in(ad_in));

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // One full bus cycle, judged pin by pin on every internal phase
    task automatic run(input logic wr, by, rf, input logic [19:0] a, input logic [15:0] wd, input logic [15:0] er);
        logic tk;
        logic rd;
        logic [15:0] wdx;
        tk = 1'b0;
        rd = !wr && !rf;
        wdx = by ? {wd[7:0], wd[7:0]} : wd;
        req_write = wr;
        req_byte = by;
        req_refresh = rf;
        req_addr = a;
        req_wdata = wd;
        req_valid = 1'b1;
        for (int i = 0; i < 20 && !tk; i++) begin
            if (req_ready === 1'b1) tk = 1'b1;
            @(negedge ref_clk);
        end
        req_valid = 1'b0;
        if (!tk) begin
            errors++;
            $display("Error req_ready expected 1 seen 0");
            return;
        end
        // Step k looks at the pins during the k-th input clock after the taking edge
        for (int k = 1; k <= 8; k++) begin
            chk("req_ready", 20'h0, {19'h0, req_ready});
            chk("ale", {19'h0, k <= 2}, {19'h0, ale});
            chk("bhe_n", {19'h0, rf ? 1'b1 : (by ? ~a[0] : 1'b0)}, {19'h0, bhe_n});
            chk("den_n", {19'h0, !(k >= 3 && k <= 6 && !rf)}, {19'h0, den_n});
            chk("addr_hi", (k <= 2) ? {16'h0, a[19:16]} : 20'h0, {16'h0, addr_hi});
            if (!rf) chk("direction", {19'h0, wr}, {19'h0, transceiver_direction});
            if (k <= 2) chk("ad_out", {4'h0, a[15:0]}, {4'h0, ad_out});
            if (k <= 2) chk("ad_oe_n", 20'h0, {19'h0, ad_oe_n});
            if (k >= 3 && k <= 6) chk("ad_data", {4'h0, (wr && !rf) ? wdx : 16'h0}, {4'h0, ad_out});
            if (k >= 3 && k <= 6) chk("ad_oe_n", {19'h0, !wr || rf}, {19'h0, ad_oe_n});
            @(negedge ref_clk);
        end
        for (int i = 0; i < 4 && done !== 1'b1; i++) @(negedge ref_clk);
        chk("done", 20'h1, {19'h0, done});
        if (rd) chk("rdata", {4'h0, er}, {4'h0, rdata});
    endtask

    task automatic s_reset();
        chk("rst_ale", 20'h0, {19'h0, ale});
        chk("rst_bhe_n", 20'h1, {19'h0, bhe_n});
        chk("rst_den_n", 20'h1, {19'h0, den_n});
        chk("rst_oe", 20'h1, {19'h0, ad_oe_n});
    endtask

    // Output may only move after a falling input edge, never after a rising one
    task automatic s_clkout();
        logic b;
        for (int i = 0; i < 6; i++) begin
            @(negedge ref_clk);
            #1 b = clkout;
            @(posedge ref_clk);
            #1 chk("clkout_rise", {19'h0, b}, {19'h0, clkout});
            @(negedge ref_clk);
            #1 chk("clkout_fall", {19'h0, ~b}, {19'h0, clkout});
        end
    endtask

    task automatic s_word();
        run(1'b1, 1'b0, 1'b0, 20'h23456, 16'ha5c3, 16'h0000);
        run(1'b0, 1'b0, 1'b0, 20'h23456, 16'h0000, 16'ha5c3);
    endtask

    task automatic s_bytes();
        run(1'b1, 1'b1, 1'b0, 20'h23457, 16'h0077, 16'h0000);
        run(1'b1, 1'b1, 1'b0, 20'h23456, 16'h0011, 16'h0000);
        run(1'b0, 1'b1, 1'b0, 20'h23457, 16'h0000, 16'h7711);
        run(1'b0, 1'b1, 1'b0, 20'hf3456, 16'h0000, 16'h7711);
    endtask

    // Refresh looks like a read of an odd address with no data enable
    task automatic s_refresh();
        run(1'b1, 1'b0, 1'b1, 20'h00001, 16'hffff, 16'h0000);
        run(1'b0, 1'b0, 1'b0, 20'h23456, 16'h0000, 16'h7711);
    endtask

    initial begin
        repeat (16) @(negedge ref_clk);
        s_reset();
        // Nonblocking release so the falling-edge reference flop still sees reset at this edge
        nrst <= 1'b1;
        s_clkout();
        @(negedge ref_clk);
        s_word();
        s_bytes();
        s_refresh();
        print_verdict();
    end
endmodule
